/* hdl/io_tracker_event_select_pkg.sv */
// constants and carrier types of the io tracker event select block
// assumes an apb master on core_clk and event strobes on the same clock

package io_tracker_event_select_pkg;

  // ***********************************************
  // register offsets
  // ***********************************************
  localparam logic [11:0] CTL0_OFS = 12'h000;
  localparam logic [11:0] CTL1_OFS = 12'h004;
  localparam logic [11:0] CTR0_OFS = 12'h008;
  localparam logic [11:0] CTR1_OFS = 12'h00c;
  localparam logic [11:0] FILT_OFS = 12'h010;

  localparam logic [31:0] CTL_RST = 32'h0000_0000;
  localparam logic [31:0] CTR_RST = 32'h0000_0000;
  localparam logic [4:0] FILT_RST = 5'h00;
  localparam int NUM_CTRS = 2;

  // ***********************************************
  // event codes and per-cycle limits
  // ***********************************************
  localparam logic [7:0] EV_DRS_INS = 8'h02;
  localparam logic [7:0] EV_DRS_FULL = 8'h05;
  localparam logic [7:0] EV_NCB_FULL = 8'h06;
  localparam logic [7:0] EV_DRS_OCC = 8'h08;
  localparam logic [7:0] EV_ACK_ALLOC = 8'h0b;
  localparam logic [7:0] EV_INBOUND = 8'h11;
  localparam logic [7:0] EV_SNOOP = 8'h12;
  localparam logic [7:0] EV_PEER_TXN = 8'h13;
  localparam logic [7:0] EV_PEER_INS = 8'h14;
  localparam logic [7:0] EV_PEER_OCC = 8'h15;
  localparam logic [7:0] EV_MISC_SET_ONE = 8'h1f;
  localparam logic [5:0] PAIR_MAX = 6'h02;
  localparam logic [6:0] OCC_MAX = 7'h3f;

  // ***********************************************
  // carrier types
  // ***********************************************
  typedef struct packed {
    logic [8:0] rsvd_hi;
    logic en;
    logic [5:0] rsvd_lo;
    logic [7:0] umask;
    logic [7:0] evsel;
  } ctl_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic [3:0] slow_xfer;
    logic lost_forward;
    logic secondary_got_insufficient_state;
    logic secondary_got_sufficient_state;
    logic peer_insert;
    logic [5:0] peer_occ_b;
    logic [5:0] peer_occ_s;
    logic peer_valid;
    logic [3:0] peer_type;
    logic peer_remote;
    logic peer_target_match;
    logic [1:0] snp_valid;
    logic [1:0][3:0] snp_resp;
    logic [1:0][2:0] snp_type;
    logic in_valid;
    logic [3:0] in_kind;
    logic [4:0] in_src_port;
    logic ack_alloc;
    logic drs_insert;
    logic drs_full;
    logic [5:0] drs_occ;
    logic ncb_full;
  } event_in_t;

  typedef struct packed {
    ctl_t [1:0] ctl;
    logic [1:0][31:0] ctr;
    logic [4:0] filt_port;
    apb_rsp_t rsp;
  } state_t;

endpackage

/* hdl/io_tracker_event_select.sv */
// event selection, qualification and two counters for the io tracker
// assumes event strobes come from logic on core_clk; apb master on core_clk
//
// Design decisions made here: the placing of the registers and the APB slave port.

`timescale 1ns/1ps

// Contract
// - misc set one counts slow i/s/e/m transfers by mask bits 0-3, max 2
// - misc set one mask bit 4 counts lost forwards
// - peer insert event adds one per peer request from inbound controller
// - peer occupancy adds b plus s queue occupancy, up to 63
// - peer transactions qualify when any selected traffic type matches
// - remote and local bits equal count all, else only the chosen side
// - bit 5 needs target match for remote, bit 7 for local
// - snoop responses count only with a response bit and a type bit set
// - inbound event counts transactions into the uncore, one per cycle
// - inbound request kinds are or-combined over selected mask bits
// - source select bit ands in a match against the filter port
// - source match compares against exactly one programmed queue
// - source select clear counts qualifying requests from all sources
// - write tracking counts writes, each retry adding one
// - inbound bits 3, 4, 5 select write prefetch, atomic, other
// - these events live only on counters 0 and 1
// - ack egress allocation event adds one per allocation
// - data response egress inserts and full cycles each add one
// - data response egress occupancy adds current occupancy, up to 63
// - noncoherent bypass egress full adds one per full cycle
// - misc set one bits 5 and 6 count insufficient and sufficient state
module io_tracker_event_select (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // register bus
  input wire io_tracker_event_select_pkg::apb_req_t apb_req,
  output io_tracker_event_select_pkg::apb_rsp_t apb_rsp,
  // event strobes from the tracker datapath
  input wire io_tracker_event_select_pkg::event_in_t ev
);

  // ***********************************************
  // event decode
  // ***********************************************

  function automatic logic [5:0] pair_cap(input logic [5:0] n);
    pair_cap = (n > io_tracker_event_select_pkg::PAIR_MAX) ?
      io_tracker_event_select_pkg::PAIR_MAX : n;
  endfunction

  function automatic logic [5:0] occ_sum(input logic [5:0] a,
                                         input logic [5:0] b);
    logic [6:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s > io_tracker_event_select_pkg::OCC_MAX) begin
      s = io_tracker_event_select_pkg::OCC_MAX;
    end
    occ_sum = s[5:0];
  endfunction

  function automatic logic [5:0] event_inc(
    input io_tracker_event_select_pkg::ctl_t c,
    input io_tracker_event_select_pkg::event_in_t e,
    input logic [4:0] port
  );
    logic [7:0] m;
    logic [6:0] hits;
    logic [5:0] n;
    logic side_ok;
    logic tgt_ok;
    logic kind_ok;
    logic src_ok;
    m = c.umask;
    hits = '0;
    n = '0;
    side_ok = 1'b0;
    tgt_ok = 1'b0;
    kind_ok = 1'b0;
    src_ok = 1'b0;
    case (c.evsel)
      io_tracker_event_select_pkg::EV_MISC_SET_ONE: begin
        hits[3:0] = e.slow_xfer & m[3:0];
        hits[4] = e.lost_forward & m[4];
        hits[5] = e.secondary_got_insufficient_state & m[5];
        hits[6] = e.secondary_got_sufficient_state & m[6];
        for (int i = 0; i < 7; i++) begin
          n = n + {5'h00, hits[i]};
        end
        n = pair_cap(n);
      end
      io_tracker_event_select_pkg::EV_PEER_INS: begin
        n = {5'h00, e.peer_insert};
      end
      io_tracker_event_select_pkg::EV_PEER_OCC: begin
        n = occ_sum(e.peer_occ_b, e.peer_occ_s);
      end
      io_tracker_event_select_pkg::EV_PEER_TXN: begin
        side_ok = (m[4] == m[6]) | (m[4] & e.peer_remote) |
                  (m[6] & ~e.peer_remote);
        tgt_ok = ~(m[5] & e.peer_remote & ~e.peer_target_match) &
                 ~(m[7] & ~e.peer_remote & ~e.peer_target_match);
        kind_ok = |(e.peer_type & m[3:0]);
        n = {5'h00, e.peer_valid & kind_ok & side_ok & tgt_ok};
      end
      io_tracker_event_select_pkg::EV_SNOOP: begin
        for (int i = 0; i < 2; i++) begin
          hits[i] = e.snp_valid[i] & (|(e.snp_resp[i] & m[3:0])) &
                    (|(e.snp_type[i] & m[6:4]));
          n = n + {5'h00, hits[i]};
        end
      end
      io_tracker_event_select_pkg::EV_INBOUND: begin
        // retried writes arrive as fresh strobes and count again
        kind_ok = |(e.in_kind & {m[5], m[4], m[3], m[1]});
        src_ok = ~m[6] | (e.in_src_port == port);
        n = {5'h00, e.in_valid & kind_ok & src_ok};
      end
      io_tracker_event_select_pkg::EV_ACK_ALLOC: begin
        n = {5'h00, e.ack_alloc};
      end
      io_tracker_event_select_pkg::EV_DRS_INS: begin
        n = {5'h00, e.drs_insert};
      end
      io_tracker_event_select_pkg::EV_DRS_FULL: begin
        n = {5'h00, e.drs_full};
      end
      io_tracker_event_select_pkg::EV_DRS_OCC: begin
        n = e.drs_occ;
      end
      io_tracker_event_select_pkg::EV_NCB_FULL: begin
        n = {5'h00, e.ncb_full};
      end
      default: begin
        n = '0;
      end
    endcase
    event_inc = n;
  endfunction

  // ***********************************************
  // state
  // ***********************************************

  io_tracker_event_select_pkg::state_t st_q;
  io_tracker_event_select_pkg::state_t st_d;
  logic setup;
  logic access;
  logic [1:0][5:0] inc;
  logic [1:0] ctr_wr;

  assign setup = apb_req.psel & ~apb_req.penable;
  assign access = apb_req.psel & apb_req.penable & st_q.rsp.pready;
  assign ctr_wr[0] = access & apb_req.pwrite &
                     (apb_req.paddr == io_tracker_event_select_pkg::CTR0_OFS);
  assign ctr_wr[1] = access & apb_req.pwrite &
                     (apb_req.paddr == io_tracker_event_select_pkg::CTR1_OFS);
  assign apb_rsp = st_q.rsp;

  always_comb begin
    for (int i = 0; i < io_tracker_event_select_pkg::NUM_CTRS; i++) begin
      inc[i] = event_inc(st_q.ctl[i], ev, st_q.filt_port);
    end
  end

  // ***********************************************
  // next state
  // ***********************************************

  always_comb begin
    io_tracker_event_select_pkg::ctl_t w;
    w = apb_req.pwdata;
    w.rsvd_hi = '0;
    w.rsvd_lo = '0;
    st_d = st_q;
    st_d.rsp.pready = 1'b0;
    st_d.rsp.pslverr = 1'b0;
    st_d.rsp.prdata = '0;
    // only two counters exist, so no other counter can take these events
    for (int i = 0; i < io_tracker_event_select_pkg::NUM_CTRS; i++) begin
      if (st_q.ctl[i].en) begin
        st_d.ctr[i] = st_q.ctr[i] + {26'h0, inc[i]};
      end
    end
    if (setup) begin
      st_d.rsp.pready = 1'b1;
      case (apb_req.paddr)
        io_tracker_event_select_pkg::CTL0_OFS: st_d.rsp.prdata = st_q.ctl[0];
        io_tracker_event_select_pkg::CTL1_OFS: st_d.rsp.prdata = st_q.ctl[1];
        io_tracker_event_select_pkg::CTR0_OFS: st_d.rsp.prdata = st_q.ctr[0];
        io_tracker_event_select_pkg::CTR1_OFS: st_d.rsp.prdata = st_q.ctr[1];
        io_tracker_event_select_pkg::FILT_OFS: begin
          st_d.rsp.prdata = {27'h0, st_q.filt_port};
        end
        default: st_d.rsp.pslverr = 1'b1;
      endcase
    end
    if (access & apb_req.pwrite) begin
      // a software write beats the increment of the same edge
      case (apb_req.paddr)
        io_tracker_event_select_pkg::CTL0_OFS: st_d.ctl[0] = w;
        io_tracker_event_select_pkg::CTL1_OFS: st_d.ctl[1] = w;
        io_tracker_event_select_pkg::CTR0_OFS: st_d.ctr[0] = apb_req.pwdata;
        io_tracker_event_select_pkg::CTR1_OFS: st_d.ctr[1] = apb_req.pwdata;
        io_tracker_event_select_pkg::FILT_OFS: begin
          st_d.filt_port = apb_req.pwdata[4:0];
        end
        default: st_d.filt_port = st_q.filt_port;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      st_q.ctl[0] <= io_tracker_event_select_pkg::CTL_RST;
      st_q.ctl[1] <= io_tracker_event_select_pkg::CTL_RST;
      st_q.ctr[0] <= io_tracker_event_select_pkg::CTR_RST;
      st_q.ctr[1] <= io_tracker_event_select_pkg::CTR_RST;
      st_q.filt_port <= io_tracker_event_select_pkg::FILT_RST;
      st_q.rsp <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ***********************************************
  // checks
  // ***********************************************

  io_tracker_event_select_pkg::ctl_t c0;
  logic run0;
  logic [31:0] delta0;
  io_tracker_event_select_pkg::ctl_t c1;
  logic run1;
  logic [31:0] delta1;

  assign c0 = st_q.ctl[0];
  assign run0 = c0.en & ~ctr_wr[0];
  assign delta0 = st_d.ctr[0] - st_q.ctr[0];
  assign c1 = st_q.ctl[1];
  assign run1 = c1.en & ~ctr_wr[1];
  assign delta1 = st_d.ctr[1] - st_q.ctr[1];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  misc_pair_cap_a: assert property (
    run0 && c0.evsel == 8'h1f && c0.umask == 8'h0f && (&ev.slow_xfer)
    |=> st_q.ctr[0] == $past(st_q.ctr[0]) + 32'h2
  ) else $error("misc set one did not add exactly two");

  lost_forward_a: assert property (
    run0 && c0.evsel == 8'h1f && c0.umask == 8'h10
    |=> st_q.ctr[0] == $past(st_q.ctr[0]) + {31'h0, $past(ev.lost_forward)}
  ) else $error("lost forward count wrong");

  peer_ins_a: assert property (
    run0 && c0.evsel == 8'h14 && !ev.peer_insert
    |=> $stable(st_q.ctr[0])
  ) else $error("peer insert counted without a request");

  peer_occ_a: assert property (
    run0 && c0.evsel == 8'h15 && ({1'b0, ev.peer_occ_b} + {1'b0, ev.peer_occ_s}) > 7'h3f
    |=> st_q.ctr[0] == $past(st_q.ctr[0]) + 32'h3f
  ) else $error("peer occupancy did not saturate at 63");

  peer_side_a: assert property (
    run0 && c0.evsel == 8'h13 && c0.umask[7:4] == 4'h1 && !ev.peer_remote
    |=> $stable(st_q.ctr[0])
  ) else $error("local peer traffic counted under remote only");

  snoop_gate_a: assert property (
    run0 && c0.evsel == 8'h12 && (c0.umask[3:0] == 4'h0 || c0.umask[6:4] == 3'h0)
    |=> $stable(st_q.ctr[0])
  ) else $error("snoop response counted without response and type bits");

  inbound_src_a: assert property (
    run0 && c0.evsel == 8'h11 && c0.umask[6] && ev.in_src_port != st_q.filt_port
    |=> $stable(st_q.ctr[0])
  ) else $error("inbound counted from an unselected source");

  inbound_all_a: assert property (
    run0 && c0.evsel == 8'h11 && !c0.umask[6] && ev.in_valid && ev.in_kind[0] && c0.umask[1]
    |=> st_q.ctr[0] == $past(st_q.ctr[0]) + 32'h1
  ) else $error("inbound write missed with source select clear");

  ncb_full_a: assert property (
    run0 && c0.evsel == 8'h06
    |-> delta0 == {31'h0, ev.ncb_full}
  ) else $error("bypass egress full count wrong");

  hold_a: assert property (
    (!c0.en && !ctr_wr[0]) [*2]
    |=> st_q.ctr[0] == $past(st_q.ctr[0], 2)
  ) else $error("disabled counter moved");

  apb_answer_a: assert property (
    setup |=> st_q.rsp.pready ##1 !st_q.rsp.pready
  ) else $error("apb answer not a single cycle after setup");

  peer_kind_a: assert property (
    run0 && c0.evsel == 8'h13 && (ev.peer_type & c0.umask[3:0]) == 4'h0
    |-> delta0 == 32'h0
  ) else $error("peer transaction counted with no selected type");

  peer_any_a: assert property (
    run0 && c0.evsel == 8'h13 && c0.umask[7:4] == 4'h0 && ev.peer_valid
    && (ev.peer_type & c0.umask[3:0]) != 4'h0
    |-> delta0 == 32'h1
  ) else $error("peer transaction of a selected type missed");

  remote_tgt_a: assert property (
    run0 && c0.evsel == 8'h13 && c0.umask[5] && ev.peer_remote && !ev.peer_target_match
    |-> delta0 == 32'h0
  ) else $error("remote peer counted without target match");

  local_tgt_a: assert property (
    run0 && c0.evsel == 8'h13 && c0.umask[7] && !ev.peer_remote && !ev.peer_target_match
    |-> delta0 == 32'h0
  ) else $error("local peer counted without target match");

  peer_ins_one_a: assert property (
    run0 && c0.evsel == 8'h14
    |-> delta0 == {31'h0, ev.peer_insert}
  ) else $error("peer insert count wrong");

  inbound_one_a: assert property (
    run0 && c0.evsel == 8'h11
    |-> delta0 <= 32'h1
  ) else $error("inbound added more than one");

  inbound_kind_a: assert property (
    run0 && c0.evsel == 8'h11
    && (ev.in_kind & {c0.umask[5], c0.umask[4], c0.umask[3], c0.umask[1]}) == 4'h0
    |-> delta0 == 32'h0
  ) else $error("inbound counted with no selected kind");

  ack_alloc_a: assert property (
    run0 && c0.evsel == 8'h0b
    |-> delta0 == {31'h0, ev.ack_alloc}
  ) else $error("ack egress allocation count wrong");

  drs_ins_a: assert property (
    run0 && c0.evsel == 8'h02
    |-> delta0 == {31'h0, ev.drs_insert}
  ) else $error("data response insert count wrong");

  drs_full_a: assert property (
    run1 && c1.evsel == 8'h05
    |-> delta1 == {31'h0, ev.drs_full}
  ) else $error("data response full count wrong");

  drs_occ_a: assert property (
    run0 && c0.evsel == 8'h08
    |-> delta0 == {26'h0, ev.drs_occ}
  ) else $error("data response occupancy count wrong");

  misc_sec_a: assert property (
    run0 && c0.evsel == 8'h1f && c0.umask == 8'h60
    |-> delta0 == {31'h0, ev.secondary_got_insufficient_state}
                  + {31'h0, ev.secondary_got_sufficient_state}
  ) else $error("secondary state count wrong");

  snoop_max_a: assert property (
    run0 && c0.evsel == 8'h12
    |-> delta0 <= 32'h2
  ) else $error("snoop responses added more than two");

  ctr_write_a: assert property (
    ctr_wr[0]
    |=> st_q.ctr[0] == $past(apb_req.pwdata)
  ) else $error("counter write did not override increment");

  ctr1_hold_a: assert property (
    !c1.en && !ctr_wr[1]
    |-> delta1 == 32'h0
  ) else $error("disabled counter one moved");

  misc_cov_c: cover property (run0 && c0.evsel == 8'h1f && delta0 == 32'h2);
  snoop_cov_c: cover property (run0 && c0.evsel == 8'h12 && delta0 == 32'h2);
  inbound_cov_c: cover property (run0 && c0.evsel == 8'h11 && c0.umask[6] && delta0 == 32'h1);
  err_cov_c: cover property (st_q.rsp.pready && st_q.rsp.pslverr);
  peer_cov_c: cover property (run0 && c0.evsel == 8'h13 && delta0 == 32'h1);

endmodule

/* dv/tracker_event_source.sv */
// event strobe source standing in for the tracker datapath
// assumes the bench pulses start on core_clk to launch a burst
`timescale 1ns/1ps
module tracker_event_source (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // burst request
  input wire logic start,
  input wire io_tracker_event_select_pkg::event_in_t burst,
  input wire logic [7:0] cnt,
  // strobes to the block
  output io_tracker_event_select_pkg::event_in_t ev,
  output logic busy
);
  logic [7:0] left_q;
  io_tracker_event_select_pkg::event_in_t burst_q;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      left_q <= 8'h00;
      burst_q <= '0;
    end else if (start) begin
      left_q <= cnt;
      burst_q <= burst;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  // strobes idle low between bursts so nothing stray is counted
  assign ev = (left_q != 8'h00) ? burst_q : '0;
  assign busy = left_q != 8'h00;
endmodule

/* dv/io_tracker_event_select_bench.sv */
// self-checking bench for the io tracker event select block
// assumes the apb slave answers after one access cycle as noted
`timescale 1ns/1ps
module io_tracker_event_select_bench;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic start = 1'b0;
  logic busy;
  logic [7:0] cnt = 8'h00;
  io_tracker_event_select_pkg::apb_req_t req = '0;
  io_tracker_event_select_pkg::apb_rsp_t rsp;
  io_tracker_event_select_pkg::event_in_t ev;
  io_tracker_event_select_pkg::event_in_t burst = '0;
  int n_fail = 0;
  int n_checks = 0;
  always #4 core_clk = ~core_clk;
  io_tracker_event_select DUT (.core_clk(core_clk), .resetn(resetn), .apb_req(req),
    .apb_rsp(rsp), .ev(ev));
  tracker_event_source src (.core_clk(core_clk), .resetn(resetn), .start(start),
    .burst(burst), .cnt(cnt), .ev(ev), .busy(busy));
  // ***********************************************
  // shared tasks
  // ***********************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge core_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge core_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  // ctl holds enable at bit 22, unit mask and event code below it
  task automatic run(input bit c1, input logic [23:0] ctl,
    input io_tracker_event_select_pkg::event_in_t e, input logic [7:0] n,
    input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    logic [11:0] ca;
    logic [11:0] ra;
    ca = c1 ? io_tracker_event_select_pkg::CTL1_OFS : io_tracker_event_select_pkg::CTL0_OFS;
    ra = c1 ? io_tracker_event_select_pkg::CTR1_OFS : io_tracker_event_select_pkg::CTR0_OFS;
    apb(1'b1, ra, 32'h0, rd, err);
    apb(1'b1, ca, {8'h00, ctl}, rd, err);
    @(posedge core_clk);
    start <= 1'b1;
    cnt <= n;
    burst <= e;
    @(posedge core_clk);
    start <= 1'b0;
    do begin
      @(posedge core_clk);
    end while (busy !== 1'b0);
    apb(1'b1, ca, 32'h0, rd, err);
    apb(1'b0, ra, 32'h0, rd, err);
    check("counter", rd, exp);
  endtask
  task automatic test_done;
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic t_regs;
    logic [31:0] rd;
    logic err;
    apb(1'b0, 12'h010, 32'h0, rd, err);
    check("filter reset", rd, 32'h0);
    apb(1'b0, 12'h014, 32'h0, rd, err);
    check("unmapped err", {31'h0, err}, 32'h1);
    apb(1'b1, 12'h004, 32'hffff_ffff, rd, err);
    apb(1'b0, 12'h004, 32'h0, rd, err);
    check("ctl bits", rd, 32'h0040_ffff);
    apb(1'b1, 12'h004, 32'h0, rd, err);
    apb(1'b1, 12'h00c, 32'h1234_5678, rd, err);
    apb(1'b0, 12'h00c, 32'h0, rd, err);
    check("ctr write", rd, 32'h1234_5678);
  endtask
  task automatic t_reset;
    logic [31:0] rd;
    logic err;
    apb(1'b1, 12'h008, 32'h0000_00a5, rd, err);
    apb(1'b1, 12'h010, 32'h0000_001f, rd, err);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    apb(1'b0, 12'h008, 32'h0, rd, err);
    check("ctr after reset", rd, 32'h0);
    apb(1'b0, 12'h010, 32'h0, rd, err);
    check("filter after reset", rd, 32'h0);
  endtask
  task automatic t_misc;
    io_tracker_event_select_pkg::event_in_t e;
    e = '0;
    e.slow_xfer = 4'hf;
    run(1'b0, 24'h40_0f1f, e, 8'h03, 32'h6);
    run(1'b0, 24'h40_011f, e, 8'h03, 32'h3);
    run(1'b0, 24'h00_0f1f, e, 8'h03, 32'h0);
    e = '0;
    e.lost_forward = 1'b1;
    run(1'b0, 24'h40_101f, e, 8'h02, 32'h2);
    e.secondary_got_insufficient_state = 1'b1;
    e.secondary_got_sufficient_state = 1'b1;
    run(1'b0, 24'h40_601f, e, 8'h04, 32'h8);
  endtask
  task automatic t_peer;
    io_tracker_event_select_pkg::event_in_t e;
    e = '0;
    e.peer_insert = 1'b1;
    run(1'b0, 24'h40_0014, e, 8'h04, 32'h4);
    e = '0;
    e.peer_occ_b = 6'h28;
    e.peer_occ_s = 6'h1e;
    run(1'b0, 24'h40_0015, e, 8'h02, 32'h7e);
    e.peer_occ_b = 6'h05;
    e.peer_occ_s = 6'h07;
    run(1'b1, 24'h40_0015, e, 8'h03, 32'h24);
    e = '0;
    e.peer_valid = 1'b1;
    e.peer_type = 4'h2;
    e.peer_remote = 1'b1;
    run(1'b0, 24'h40_0213, e, 8'h03, 32'h3);
    run(1'b0, 24'h40_0d13, e, 8'h03, 32'h0);
    run(1'b0, 24'h40_1213, e, 8'h03, 32'h3);
    run(1'b0, 24'h40_4213, e, 8'h03, 32'h0);
    run(1'b0, 24'h40_5213, e, 8'h03, 32'h3);
    run(1'b0, 24'h40_2213, e, 8'h03, 32'h0);
    e.peer_target_match = 1'b1;
    run(1'b0, 24'h40_2213, e, 8'h03, 32'h3);
    e.peer_remote = 1'b0;
    e.peer_target_match = 1'b0;
    run(1'b0, 24'h40_8213, e, 8'h03, 32'h0);
    run(1'b0, 24'h40_1213, e, 8'h03, 32'h0);
  endtask
  task automatic t_snoop;
    io_tracker_event_select_pkg::event_in_t e;
    e = '0;
    e.snp_valid = 2'h3;
    e.snp_resp[0] = 4'h1;
    e.snp_resp[1] = 4'h1;
    e.snp_type[0] = 3'h2;
    e.snp_type[1] = 3'h4;
    run(1'b0, 24'h40_7112, e, 8'h03, 32'h6);
    run(1'b0, 24'h40_7e12, e, 8'h03, 32'h0);
    run(1'b0, 24'h40_0f12, e, 8'h03, 32'h0);
    run(1'b1, 24'h40_2112, e, 8'h03, 32'h3);
  endtask
  task automatic t_inbound;
    io_tracker_event_select_pkg::event_in_t e;
    logic [31:0] rd;
    logic err;
    apb(1'b1, 12'h010, 32'h5, rd, err);
    e = '0;
    e.in_valid = 1'b1;
    e.in_kind = 4'h1;
    e.in_src_port = 5'h06;
    run(1'b0, 24'h40_0211, e, 8'h04, 32'h4);
    run(1'b0, 24'h40_4211, e, 8'h04, 32'h0);
    run(1'b0, 24'h40_3811, e, 8'h04, 32'h0);
    e.in_src_port = 5'h05;
    run(1'b0, 24'h40_4211, e, 8'h04, 32'h4);
    for (int i = 0; i < 3; i++) begin
      e.in_kind = 4'h2 << i;
      run(1'b0, {8'h40, 8'h08 << i, 8'h11}, e, 8'h02, 32'h2);
    end
    run(1'b0, 24'h40_3a11, e, 8'h02, 32'h2);
  endtask
  task automatic t_egress;
    io_tracker_event_select_pkg::event_in_t e;
    e = '0;
    e.ack_alloc = 1'b1;
    e.drs_insert = 1'b1;
    e.drs_full = 1'b1;
    e.ncb_full = 1'b1;
    e.drs_occ = 6'h2a;
    run(1'b0, 24'h40_000b, e, 8'h03, 32'h3);
    run(1'b0, 24'h40_0002, e, 8'h03, 32'h3);
    run(1'b1, 24'h40_0005, e, 8'h03, 32'h3);
    run(1'b0, 24'h40_0006, e, 8'h03, 32'h3);
    run(1'b0, 24'h40_0008, e, 8'h03, 32'h7e);
    e.drs_occ = 6'h3f;
    run(1'b1, 24'h40_0008, e, 8'h02, 32'h7e);
  endtask
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    t_regs();
    t_reset();
    t_misc();
    t_peer();
    t_snoop();
    t_inbound();
    t_egress();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    test_done();
  end
endmodule
